// ===== inc/ahrp_defines.svh
// Constants for the asynchronous host register port.
// Assumes inclusion by bare name from the design files.
`ifndef AHRP_DEFINES_SVH
`define AHRP_DEFINES_SVH

// Data bus width.
`define AHRP_DATA_W 8
// Address bus width, not counting the space select bit.
`define AHRP_ADDR_W 9
// Number of alarm sources.
`define AHRP_NUM_SRC 7
// Base addresses inside the normal register space.
`define AHRP_ADDR_STATUS 9'h000
`define AHRP_ADDR_MASK 9'h001
`define AHRP_ADDR_LIVE 9'h002
`define AHRP_ADDR_SCRATCH 9'h003
// Base address inside the test register space.
`define AHRP_ADDR_TEST 9'h000
// Reset values.
`define AHRP_MASK_RST 7'h00
`define AHRP_SCRATCH_RST 8'h00
// Bit positions of the alarm sources.
`define AHRP_BIT_SIG_LOSS 0
`define AHRP_BIT_FRAME_LOSS 1
`define AHRP_BIT_LINE_AIS 2
`define AHRP_BIT_LINE_RDI 3
`define AHRP_BIT_PTR_LOSS 4
`define AHRP_BIT_PATH_AIS 5
`define AHRP_BIT_PATH_RDI 6

`endif

// ===== inc/ahrp_pkg.sv
// Types for the asynchronous host register port.
// Assumes the defines header is compiled alongside.
package ahrp_pkg;

  // Phases of one host strobe cycle as seen by the core clock.
  typedef enum logic [1:0] {
    AHRP_IDLE,
    AHRP_READ,
    AHRP_WRITE
  } ahrp_phase_type;

endpackage

// ===== design/ahrp_sync.sv
// Two flip-flop synchroniser, one instance per pin group.
// Assumes a single core clock with a synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module ahrp_sync
#(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // First stage, read by the second stage only.
  logic [WIDTH-1:0] meta_reg;

  // Two stages; both take the idle value in reset.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule // ahrp_sync

`default_nettype wire

// ===== design/ahrp_port.sv
// Strobe-timed 8-bit host register port with alarm interrupt.
// Assumes host pins are asynchronous to sys_clk; the external device
// reset pin is merged with rst into one internal reset.
`timescale 1ns/1ns
`default_nettype none
`include "ahrp_defines.svh"

module ahrp_port
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    device_reset_n,
  input  wire logic                    chip_select_n,
  input  wire logic                    read_strobe_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    addr_latch_en,
  input  wire logic [`AHRP_ADDR_W-1:0] addr,
  input  wire logic                    test_space_sel,
  input  wire logic [`AHRP_DATA_W-1:0] data_in,
  output logic      [`AHRP_DATA_W-1:0] data_out,
  output logic                         data_oe,
  input  wire logic                    signal_loss,
  input  wire logic                    frame_loss,
  input  wire logic                    line_ais,
  input  wire logic                    line_remote_defect,
  input  wire logic                    pointer_loss,
  input  wire logic                    path_ais,
  input  wire logic                    path_remote_defect,
  output logic                         interrupt_out_n,
  output logic                         interrupt_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisation.

  // Reset flops of the device reset pin, asserted at once, freed late.
  logic       dev_rst_meta_reg;
  logic       dev_rst_reg;
  // Combined internal reset.
  logic       core_rst;

  // Asynchronous assertion from the pin, synchronous release.
  always_ff @(posedge sys_clk or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      dev_rst_meta_reg <= 1'b1;
      dev_rst_reg      <= 1'b1;
    end
    else
    begin
      dev_rst_meta_reg <= 1'b0;
      dev_rst_reg      <= dev_rst_meta_reg;
    end
  end

  assign core_rst = rst | dev_rst_reg;

  // Synchronised strobe group: chip select, read, write, latch enable.
  logic [3:0] strb_s;
  // Synchronised address with space bit, and data.
  logic [`AHRP_ADDR_W:0]   addr_s;
  logic [`AHRP_DATA_W-1:0] data_s;
  // Synchronised alarm sources.
  logic [`AHRP_NUM_SRC-1:0] src_s;

  ahrp_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_sync_strb
  (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .din     ({chip_select_n, read_strobe_n, write_strobe_n,
               addr_latch_en}),
    .dout    (strb_s)
  );

  ahrp_sync #(.WIDTH(`AHRP_ADDR_W + 1)) u_sync_addr
  (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .din     ({test_space_sel, addr}),
    .dout    (addr_s)
  );

  ahrp_sync #(.WIDTH(`AHRP_DATA_W)) u_sync_data
  (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .din     (data_in),
    .dout    (data_s)
  );

  ahrp_sync #(.WIDTH(`AHRP_NUM_SRC)) u_sync_src
  (
    .sys_clk (sys_clk),
    .rst     (core_rst),
    .din     ({path_remote_defect, path_ais, pointer_loss,
               line_remote_defect, line_ais, frame_loss, signal_loss}),
    .dout    (src_s)
  );

  // Named views of the synchronised strobes.
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic ale_s;
  assign {cs_n_s, rd_n_s, wr_n_s, ale_s} = strb_s;

  ////////////////////////////////////////////////////////////////////////
  // Address latch and decode.

  // Held address including the space bit in the top position.
  logic [`AHRP_ADDR_W:0] addr_hold_reg;
  // Address actually used for the access.
  logic [`AHRP_ADDR_W:0] addr_eff;

  // Follows the bus while enable is high, keeps it while low.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      addr_hold_reg <= '0;
    else if (ale_s)
      addr_hold_reg <= addr_s;
  end

  // Transparent path while enable is high, held copy otherwise.
  assign addr_eff = ale_s ? addr_s : addr_hold_reg;

  // Matches a normal or test space address against a target.
  function automatic logic hit(input logic [`AHRP_ADDR_W:0] a,
                               input logic                  test,
                               input logic [`AHRP_ADDR_W-1:0] t);
    hit = (a[`AHRP_ADDR_W] == test) && (a[`AHRP_ADDR_W-1:0] == t);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strobe qualification.

  // Strobes count only while chip select is low.
  logic rd_act;
  logic wr_act;
  assign rd_act = !cs_n_s && !rd_n_s;
  assign wr_act = !cs_n_s && !wr_n_s;

  // Current access phase.
  ahrp_pkg::ahrp_phase_type phase_reg;
  // Write rising edge seen this cycle, chip select still low.
  logic                     wr_done;
  // Read end seen this cycle.
  logic                     rd_done;
  // Address captured at start of the access.
  logic [`AHRP_ADDR_W:0]    acc_addr_reg;

  // Tracks one read or write from strobe fall to strobe rise.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      phase_reg <= ahrp_pkg::AHRP_IDLE;
    else
    begin
      unique case (phase_reg)
        ahrp_pkg::AHRP_IDLE:
          if (wr_act)
            phase_reg <= ahrp_pkg::AHRP_WRITE;
          else if (rd_act)
            phase_reg <= ahrp_pkg::AHRP_READ;
        ahrp_pkg::AHRP_READ:
          if (!rd_act)
            phase_reg <= ahrp_pkg::AHRP_IDLE;
        ahrp_pkg::AHRP_WRITE:
          if (wr_n_s || cs_n_s)
            phase_reg <= ahrp_pkg::AHRP_IDLE;
      endcase
    end
  end

  // Address of the access in flight, held stable by the host.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      acc_addr_reg <= '0;
    else if (phase_reg == ahrp_pkg::AHRP_IDLE)
      acc_addr_reg <= addr_eff;
  end

  // Rising write strobe with chip select low commits the write.
  assign wr_done = (phase_reg == ahrp_pkg::AHRP_WRITE)
                   && wr_n_s && !cs_n_s;
  assign rd_done = (phase_reg == ahrp_pkg::AHRP_READ) && !rd_act;

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  // Sticky alarm status, mask, scratch and test registers.
  logic [`AHRP_NUM_SRC-1:0] status_reg;
  logic [`AHRP_NUM_SRC-1:0] mask_reg;
  logic [`AHRP_DATA_W-1:0]  scratch_reg;
  logic [`AHRP_DATA_W-1:0]  test_reg;
  // Previous source levels, for rising edge detection.
  logic [`AHRP_NUM_SRC-1:0] src_prev_reg;
  // Rising edges of sources this cycle.
  logic [`AHRP_NUM_SRC-1:0] src_rise;
  // Status read completed: clears what was read.
  logic                     stat_ack;
  // Snapshot of status returned by the read in flight.
  logic [`AHRP_NUM_SRC-1:0] stat_seen_reg;

  assign src_rise = src_s & ~src_prev_reg;
  assign stat_ack = rd_done
                    && hit(acc_addr_reg, 1'b0, `AHRP_ADDR_STATUS);

  // Previous source level.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      src_prev_reg <= '0;
    else
      src_prev_reg <= src_s;
  end

  // Reading the status acknowledges the bits returned; a new event wins.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~(stat_ack ? stat_seen_reg : '0))
                    | src_rise;
  end

  // Mask register written by the host.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      mask_reg <= `AHRP_MASK_RST;
    else if (wr_done && hit(acc_addr_reg, 1'b0, `AHRP_ADDR_MASK))
      mask_reg <= data_s[`AHRP_NUM_SRC-1:0];
  end

  // General scratch register.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      scratch_reg <= `AHRP_SCRATCH_RST;
    else if (wr_done && hit(acc_addr_reg, 1'b0, `AHRP_ADDR_SCRATCH))
      scratch_reg <= data_s;
  end

  // Test space register, reached only with the space bit high.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      test_reg <= '0;
    else if (wr_done && hit(acc_addr_reg, 1'b1, `AHRP_ADDR_TEST))
      test_reg <= data_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data path.

  // Value of the addressed register; unmapped reads return zero.
  logic [`AHRP_DATA_W-1:0] rd_mux;

  // Selects the register named by the access address.
  always_comb
  begin
    rd_mux = '0;
    if (hit(acc_addr_reg, 1'b0, `AHRP_ADDR_STATUS))
      rd_mux = {1'b0, status_reg};
    else if (hit(acc_addr_reg, 1'b0, `AHRP_ADDR_MASK))
      rd_mux = {1'b0, mask_reg};
    else if (hit(acc_addr_reg, 1'b0, `AHRP_ADDR_LIVE))
      rd_mux = {1'b0, src_s};
    else if (hit(acc_addr_reg, 1'b0, `AHRP_ADDR_SCRATCH))
      rd_mux = scratch_reg;
    else if (hit(acc_addr_reg, 1'b1, `AHRP_ADDR_TEST))
      rd_mux = test_reg;
  end

  // Status bits seen by this read, latched while the read is held.
  always_ff @(posedge sys_clk)
  begin
    if (core_rst || phase_reg != ahrp_pkg::AHRP_READ)
      stat_seen_reg <= '0;
    else
      stat_seen_reg <= status_reg;
  end

  // Drives the bus only during a qualified read; pin reset acts at once.
  always_ff @(posedge sys_clk or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_oe  <= !core_rst && (phase_reg == ahrp_pkg::AHRP_READ)
                  && rd_act;
      data_out <= core_rst ? '0 : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt output.

  // Pulls low while any unmasked sticky alarm remains; pin reset frees it.
  always_ff @(posedge sys_clk or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      interrupt_out_n <= 1'b0;
      interrupt_oe    <= 1'b0;
    end
    else
    begin
      interrupt_out_n <= 1'b0;
      interrupt_oe    <= !core_rst && (|(status_reg & mask_reg));
    end
  end

endmodule // ahrp_port

`default_nettype wire

// ===== tb/ahrp_port_assertions.sv
// Pin-level checker for the host register port.
// Assumes one core clock and the synchronous reset rst.
`timescale 1ns/1ns
`default_nettype none
`include "ahrp_defines.svh"

module ahrp_port_assertions
(
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic                    device_reset_n,
  input wire logic                    chip_select_n,
  input wire logic                    read_strobe_n,
  input wire logic                    write_strobe_n,
  input wire logic                    addr_latch_en,
  input wire logic [`AHRP_ADDR_W-1:0] addr,
  input wire logic                    test_space_sel,
  input wire logic [`AHRP_DATA_W-1:0] data_in,
  input wire logic [`AHRP_DATA_W-1:0] data_out,
  input wire logic                    data_oe,
  input wire logic                    signal_loss,
  input wire logic                    frame_loss,
  input wire logic                    line_ais,
  input wire logic                    line_remote_defect,
  input wire logic                    pointer_loss,
  input wire logic                    path_ais,
  input wire logic                    path_remote_defect,
  input wire logic                    interrupt_out_n,
  input wire logic                    interrupt_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] idle_reg;  // Cycles since the host last selected us.
  logic [6:0] src;       // All alarm inputs side by side.
  assign src = {path_remote_defect, path_ais, pointer_loss,
                line_remote_defect, line_ais, frame_loss, signal_loss};
  // Saturating count of unselected cycles.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !chip_select_n)
      idle_reg <= 4'h0;
    else if (idle_reg != 4'hf)
      idle_reg <= idle_reg + 4'h1;
  end
  a_read_start:
    assert property ($rose(data_oe) |->
      $past(!chip_select_n && !read_strobe_n && write_strobe_n, 2))
    else $error("data bus driven without a selected read");
  a_read_end:
    assert property (read_strobe_n [*4] |-> !data_oe)
    else $error("data bus still driven after read ended");
  a_cs_gate:
    assert property (chip_select_n [*4] |-> !data_oe)
    else $error("data bus driven while not selected");
  a_oe_holds:
    assert property ($rose(data_oe) |=> data_oe)
    else $error("read data dropped too early");
  a_open_drain:
    assert property (!interrupt_out_n)
    else $error("interrupt pin level is not low");
  a_int_cause:
    assert property ($rose(interrupt_oe) |-> $past(src != 7'h00, 2))
    else $error("interrupt without an alarm");
  a_reset_quiet:
    assert property (!device_reset_n |-> !interrupt_oe && !data_oe)
    else $error("outputs active during pin reset");
  a_int_release:
    assert property ($fell(interrupt_oe) |->
      idle_reg < 4'hc || !device_reset_n)
    else $error("interrupt released without host access");
  cover property ($rose(data_oe));
  cover property ($rose(interrupt_oe));
  cover property ($fell(interrupt_oe));
endmodule // ahrp_port_assertions

bind ahrp_port ahrp_port_assertions ahrp_port_assertions_i (.*);
`default_nettype wire

// ===== tb/ahrp_host_model.sv
// Host processor model driving the strobe-timed register bus.
// Assumes the bench calls its tasks; one access at a time.
`timescale 1ns/1ns
`default_nettype none
`include "ahrp_defines.svh"

module ahrp_host_model
(
  input  wire logic                    sys_clk,
  output logic                         chip_select_n,
  output logic                         read_strobe_n,
  output logic                         write_strobe_n,
  output logic                         addr_latch_en,
  output logic      [`AHRP_ADDR_W-1:0] addr,
  output logic                         test_space_sel,
  output wire logic [`AHRP_DATA_W-1:0] data_in,
  input  wire logic [`AHRP_DATA_W-1:0] data_out,
  input  wire logic                    data_oe
);
  logic [7:0] hd;    // Last value the host put on the bus.
  logic       hdrv;  // High while the host drives the bus.
  // Released bus shows the port's data while data_oe, else a stale inverse so nothing reads as valid.
  assign data_in = hdrv ? hd : (data_oe ? data_out : ~hd);
  // Idle levels; select stays high through reset.
  initial
  begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr_latch_en = 1'b1;
    addr = '0;
    test_space_sel = 1'b0;
    hd = 8'h00;
    hdrv = 1'b0;
  end
  // One access; sel low leaves chip select high.
  task automatic access(input bit w, input bit sel, input logic ts,
                        input logic [8:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge sys_clk) #1;
    addr = a;
    test_space_sel = ts;
    hd = d;
    hdrv = w;
    chip_select_n = !sel;
    @(posedge sys_clk) #1;
    write_strobe_n = !w;
    read_strobe_n = w;
    repeat (6) @(posedge sys_clk);
    #1;
    q = data_oe ? data_out : 'x;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chip_select_n = 1'b1;
    hdrv = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // Loads the address latch; hold keeps it closed afterwards.
  task automatic latch(input bit hold, input logic [8:0] a);
    @(posedge sys_clk) #1;
    addr_latch_en = 1'b1;
    addr = a;
    repeat (4) @(posedge sys_clk);
    #1;
    addr_latch_en = !hold;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
endmodule // ahrp_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the host register port.
// Assumes the host model and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`include "ahrp_defines.svh"

module testbench;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       device_reset_n = 1'b1;
  logic [6:0] src = 7'h00;  // Alarm levels.
  logic [7:0] q;            // Last read result.
  int         n_mismatch = 0;
  int         n_compared = 0;
  wire logic chip_select_n, read_strobe_n, write_strobe_n, addr_latch_en;
  wire logic test_space_sel, data_oe, interrupt_out_n, interrupt_oe;
  wire logic [`AHRP_ADDR_W-1:0] addr;
  wire logic [`AHRP_DATA_W-1:0] data_in, data_out;
  wire logic signal_loss, frame_loss, line_ais, line_remote_defect;
  wire logic pointer_loss, path_ais, path_remote_defect;
  assign {path_remote_defect, path_ais, pointer_loss, line_remote_defect,
          line_ais, frame_loss, signal_loss} = src;
  ahrp_port ahrp_port_i (.*);
  ahrp_host_model ahrp_host_model_i (.*);
  always #2 sys_clk = ~sys_clk;
  // Counts and reports one comparison.
  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic ts, logic [8:0] a, logic [7:0] d);
    ahrp_host_model_i.access(1, 1, ts, a, d, q);
  endtask
  task automatic rd(logic ts, logic [8:0] a, string n, logic [7:0] e);
    ahrp_host_model_i.access(0, 1, ts, a, 8'h00, q);
    cmp(n, e, q);
  endtask
  // Waits a bounded time for the interrupt level, then judges it.
  task automatic wait_int(logic e);
    repeat (12) if (interrupt_oe !== e) @(posedge sys_clk) #1;
    cmp("interrupt_oe", {7'h00, e}, {7'h00, interrupt_oe});
    cmp("interrupt_out_n", 8'h00, {7'h00, interrupt_out_n});
  endtask
  task automatic t_basic;
    rd(0, `AHRP_ADDR_MASK, "mask", 8'h00);
    rd(0, `AHRP_ADDR_SCRATCH, "scratch", `AHRP_SCRATCH_RST);
    wr(0, `AHRP_ADDR_SCRATCH, 8'ha5);
    rd(0, `AHRP_ADDR_SCRATCH, "scratch", 8'ha5);
    ahrp_host_model_i.access(1, 0, 0, `AHRP_ADDR_SCRATCH, 8'h3c, q);
    ahrp_host_model_i.access(0, 0, 0, `AHRP_ADDR_SCRATCH, 8'h00, q);
    cmp("idle bus", 8'hxx, q);
    rd(0, `AHRP_ADDR_SCRATCH, "scratch", 8'ha5);
  endtask
  task automatic t_space;
    wr(1, `AHRP_ADDR_TEST, 8'h69);
    rd(1, `AHRP_ADDR_TEST, "test", 8'h69);
    rd(0, `AHRP_ADDR_STATUS, "status", 8'h00);
  endtask
  task automatic t_latch;
    ahrp_host_model_i.latch(1, `AHRP_ADDR_SCRATCH);
    wr(0, `AHRP_ADDR_MASK, 8'h1e);
    ahrp_host_model_i.latch(0, `AHRP_ADDR_SCRATCH);
    rd(0, `AHRP_ADDR_SCRATCH, "latched", 8'h1e);
    rd(0, `AHRP_ADDR_MASK, "mask", 8'h00);
  endtask
  task automatic t_irq;
    wr(0, `AHRP_ADDR_MASK, 8'h7f);
    for (int i = 0; i < 7; i++)
    begin
      src = 7'h01 << i;
      wait_int(1);
      rd(0, `AHRP_ADDR_LIVE, "live", 8'h01 << i);
      rd(0, `AHRP_ADDR_STATUS, "status", 8'h01 << i);
      wait_int(0);
      src = 7'h00;
    end
    wr(0, `AHRP_ADDR_MASK, 8'h00);
    src = 7'h7f;
    repeat (12) @(posedge sys_clk);
    wait_int(0);
    src = 7'h00;
    rd(0, `AHRP_ADDR_STATUS, "status", 8'h7f);
  endtask
  task automatic t_arst;
    wr(0, `AHRP_ADDR_MASK, 8'h01);
    src = 7'h01;
    wait_int(1);
    device_reset_n = 1'b0;
    #1 cmp("pin reset", 8'h00, {7'h00, interrupt_oe});
    repeat (3) @(posedge sys_clk);
    #1 device_reset_n = 1'b1;
    src = 7'h00;
    repeat (5) @(posedge sys_clk);
    rd(0, `AHRP_ADDR_MASK, "mask", 8'h00);
  endtask
  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence after three reset cycles.
  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    t_basic();
    t_space();
    t_latch();
    t_irq();
    t_arst();
    final_report();
  end
  // Watchdog well beyond the expected run.
  initial
  begin
    #40000;
    n_mismatch++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
